// ### mes_regs.svh
// register offsets, field positions, reset values for the event status block
`ifndef MES_REGS_SVH
`define MES_REGS_SVH

// byte offsets on the apb slave
`define MES_OFF_LINK_RAW 8'h00
`define MES_OFF_LINK_MASKED 8'h04
`define MES_OFF_CMD_RAW 8'h08
`define MES_OFF_CONTROL 8'h0C
`define MES_OFF_LINK_STATE 8'h10
`define MES_OFF_INT_STATUS 8'h14
`define MES_OFF_INT_CLEAR 8'h18
`define MES_OFF_INT_ENABLE 8'h1C

// control register field
`define MES_CTRL_TEST_EN_BIT 17

// interrupt status layout: two channels per event kind
`define MES_INT_LINK_RAW_LSB 0
`define MES_INT_LINK_MASKED_LSB 2
`define MES_INT_CMD_LSB 4
`define MES_INT_W 6

// reset values
`define MES_RST_EVENT 1'h0
`define MES_RST_TEST_EN 1'h0
`define MES_RST_LINK_STATE 32'h0000_0000
`define MES_RST_INT 6'h00
`define MES_RST_RDATA 32'h0000_0000

`endif

// ### mes_pkg.sv
// types shared by the event status block
package mes_pkg;

  // one completed read of a phy generic status register
  typedef struct packed {
    logic done;
    logic [4:0] addr;
    logic link;
  } mes_status_rd_t;

  // per-channel phy select settings held outside this block
  typedef struct packed {
    logic [4:0] addr;
    logic link_int_enable;
  } mes_phy_sel_t;

  // apb request fields that travel together
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } mes_apb_req_t;

endpackage

// ### mes_event_cell.sv
// one sticky event bit: hardware set, write-one clear, test-mode set
`include "mes_regs.svh"

module mes_event_cell
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_hw_set,
  input wire logic i_wr_one,
  input wire logic i_test_en,
  output logic o_bit
);

  logic next_bit;

  // hardware set beats a clear in the same cycle; test mode turns a one into a set
  always_comb
  begin
    next_bit = i_hw_set | (i_wr_one & i_test_en) | (o_bit & ~i_wr_one);
  end

  // the bit itself
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_bit <= `MES_RST_EVENT;
    else
      o_bit <= next_bit;
  end

endmodule

// ### mes_event_status.sv
// link-change and command-complete event latching with apb register access
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "mes_regs.svh"

// Operation
// R1: event register bits 31-2 read zero, ignore writes
// R2: link change on selected phy sets raw bit
// R3: write one clears raw link bit
// R4: test enable lets written ones set bits
// R5: masked link bit needs change and enable
// R6: write one clears masked link bit
// R7: finished user command sets raw done bit
// R8: write one clears raw done bit
// R9: control bit 17 is the test enable
// R10: link state refreshed on status register reads
// R11: reset clears events; event beats clear
module mes_event_status #(
  parameter int NCH = 2
)
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire mes_pkg::mes_status_rd_t i_status_rd,
  input wire mes_pkg::mes_phy_sel_t [NCH-1:0] i_phy_sel,
  input wire logic [NCH-1:0] i_cmd_done,
  output logic [NCH-1:0] o_link_raw,
  output logic [NCH-1:0] o_link_masked,
  output logic [NCH-1:0] o_cmd_raw,
  output logic o_test_en,
  output logic [31:0] o_link_state,
  output logic o_irq
);

  mes_pkg::mes_apb_req_t req;
  logic access;
  logic wr;
  logic setup;
  logic hit;
  logic [31:0] rd_mux;
  logic [NCH-1:0] wr_link_raw;
  logic [NCH-1:0] wr_link_masked;
  logic [NCH-1:0] wr_cmd_raw;
  logic [NCH-1:0] link_evt;
  logic [NCH-1:0] link_mevt;
  logic link_changed;
  logic [`MES_INT_W-1:0] int_status;
  logic [`MES_INT_W-1:0] int_enable;
  logic [`MES_INT_W-1:0] int_evt;
  logic [`MES_INT_W-1:0] int_clr;
  logic [`MES_INT_W-1:0] next_int_status;

  // gather the request and the apb phases
  assign req = '{paddr: i_paddr, pwrite: i_pwrite, pwdata: i_pwdata};
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr = access & req.pwrite;

  // zero wait states; unmapped access flags an error
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~hit;

  // write-one strobes per event register, only the channel bits taken [R1]
  always_comb
  begin
    wr_link_raw = '0;
    wr_link_masked = '0;
    wr_cmd_raw = '0;
    if (wr && req.paddr == `MES_OFF_LINK_RAW)
      wr_link_raw = req.pwdata[NCH-1:0]; // [R3]
    if (wr && req.paddr == `MES_OFF_LINK_MASKED)
      wr_link_masked = req.pwdata[NCH-1:0]; // [R6]
    if (wr && req.paddr == `MES_OFF_CMD_RAW)
      wr_cmd_raw = req.pwdata[NCH-1:0]; // [R8]
  end

  // a status read whose link bit differs from the stored one is a change
  assign link_changed = i_status_rd.done &
                        (i_status_rd.link != o_link_state[i_status_rd.addr]);

  // clock and reset for every check below, channel checks included
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  // per-channel event detection and the three sticky bits
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      // change on the address this channel watches
      assign link_evt[ch] = link_changed &
                            (i_status_rd.addr == i_phy_sel[ch].addr); // [R2]
      // masked copy only with the channel's link interrupt enable
      assign link_mevt[ch] = link_evt[ch] & i_phy_sel[ch].link_int_enable; // [R5]

      mes_event_cell u_link_raw
      (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_hw_set(link_evt[ch]),
        .i_wr_one(wr_link_raw[ch]),
        .i_test_en(o_test_en),
        .o_bit(o_link_raw[ch])
      );

      mes_event_cell u_link_masked
      (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_hw_set(link_mevt[ch]),
        .i_wr_one(wr_link_masked[ch]),
        .i_test_en(o_test_en),
        .o_bit(o_link_masked[ch])
      );

      mes_event_cell u_cmd_raw
      (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_hw_set(i_cmd_done[ch]), // [R7]
        .i_wr_one(wr_cmd_raw[ch]),
        .i_test_en(o_test_en), // [R4]
        .o_bit(o_cmd_raw[ch])
      );

      // hardware event sets the raw link bit next edge, even against a clear
      a_link_raw_set: assert property (link_evt[ch] |=> o_link_raw[ch]) // [R2] [R11]
        else $error("raw link bit not set after link change");

      // a write of one outside test mode clears when no event competes
      a_link_raw_clr: assert property (
        wr_link_raw[ch] && !o_test_en && !link_evt[ch] |=> !o_link_raw[ch]) // [R3]
        else $error("raw link bit not cleared by write of one");

      // test mode turns a written one into a set on the raw done bit
      a_test_sets: assert property (
        o_test_en && wr_cmd_raw[ch] |=> o_cmd_raw[ch] && $stable(o_test_en)) // [R4]
        else $error("test-mode write of one did not set the bit");

      // masked bit rises only from an enabled change or a test-mode write
      a_masked_gate: assert property (
        $rose(o_link_masked[ch]) |->
          $past(link_mevt[ch]) || $past(o_test_en && wr_link_masked[ch])) // [R5]
        else $error("masked link bit set without enabled change");

      // masked bit clears on a write of one with nothing competing
      a_masked_clr: assert property (
        wr_link_masked[ch] && !o_test_en && !link_mevt[ch] |=> !o_link_masked[ch]) // [R6]
        else $error("masked link bit not cleared by write of one");

      // command completion sets the raw done bit at the next edge
      a_cmd_set: assert property (i_cmd_done[ch] |=> o_cmd_raw[ch]) // [R7]
        else $error("raw done bit not set after command completion");

      // raw done bit clears on write of one, holds on write of zero
      a_cmd_clr: assert property (
        wr && req.paddr == `MES_OFF_CMD_RAW && !o_test_en && !i_cmd_done[ch] |=>
          o_cmd_raw[ch] == ($past(o_cmd_raw[ch]) & ~$past(req.pwdata[ch]))) // [R8]
        else $error("raw done bit wrong after write");
    end
  endgenerate

  // control register: only the test enable is stored [R9]
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_test_en <= `MES_RST_TEST_EN;
    else if (wr && req.paddr == `MES_OFF_CONTROL)
      o_test_en <= req.pwdata[`MES_CTRL_TEST_EN_BIT]; // [R9]
  end

  // per-address link state, refreshed on each status register read
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_link_state <= `MES_RST_LINK_STATE;
    else if (i_status_rd.done)
      o_link_state[i_status_rd.addr] <= i_status_rd.link; // [R10]
  end

  // interrupt events and write-one clears in status layout
  assign int_evt = {i_cmd_done, link_mevt, link_evt};
  assign int_clr = (wr && req.paddr == `MES_OFF_INT_CLEAR) ?
                   req.pwdata[`MES_INT_W-1:0] : `MES_RST_INT;

  // set wins over clear so no event is lost
  always_comb
  begin
    next_int_status = int_evt | (int_status & ~int_clr);
  end

  // sticky interrupt status
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      int_status <= `MES_RST_INT;
    else
      int_status <= next_int_status;
  end

  // interrupt enable register
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      int_enable <= `MES_RST_INT;
    else if (wr && req.paddr == `MES_OFF_INT_ENABLE)
      int_enable <= req.pwdata[`MES_INT_W-1:0];
  end

  // level interrupt while any enabled status bit is set
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_irq <= 1'h0;
    else
      o_irq <= |(next_int_status & int_enable);
  end

  // read decode; upper bits of event registers always zero
  always_comb
  begin
    rd_mux = '0;
    hit = 1'b1;
    case (req.paddr)
      `MES_OFF_LINK_RAW: rd_mux[NCH-1:0] = o_link_raw; // [R1]
      `MES_OFF_LINK_MASKED: rd_mux[NCH-1:0] = o_link_masked; // [R1]
      `MES_OFF_CMD_RAW: rd_mux[NCH-1:0] = o_cmd_raw; // [R1]
      `MES_OFF_CONTROL: rd_mux[`MES_CTRL_TEST_EN_BIT] = o_test_en;
      `MES_OFF_LINK_STATE: rd_mux = o_link_state;
      `MES_OFF_INT_STATUS: rd_mux[`MES_INT_W-1:0] = int_status;
      `MES_OFF_INT_CLEAR: rd_mux = '0;
      `MES_OFF_INT_ENABLE: rd_mux[`MES_INT_W-1:0] = int_enable;
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, held through the access
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_prdata <= `MES_RST_RDATA;
    else if (setup)
      o_prdata <= rd_mux;
  end

  // checks shared by all channels
  // event register reads never show anything above the channel bits
  a_upper_zero: assert property (
    access && !req.pwrite && req.paddr <= `MES_OFF_CMD_RAW |->
      (o_prdata >> NCH) == 32'h0000_0000) // [R1]
    else $error("event register upper bits not zero");

  // control write loads the test enable from bit 17 of the data
  a_test_bit: assert property (
    wr && req.paddr == `MES_OFF_CONTROL |=>
      o_test_en == $past(req.pwdata[`MES_CTRL_TEST_EN_BIT])) // [R9]
    else $error("test enable does not follow control bit 17");

  // stored link state takes the value of each status read
  a_link_refresh: assert property (
    i_status_rd.done |=> o_link_state[$past(i_status_rd.addr)] == $past(i_status_rd.link)) // [R10]
    else $error("link state not refreshed by status read");

  // no change is seen when the same value is read twice in a row
  a_no_false_change: assert property (
    i_status_rd.done ##1 (i_status_rd.done && $stable(i_status_rd)) |-> !link_changed) // [R10]
    else $error("link change flagged without a change");

  // interrupt level rises in the same cycle as the enabled status bit it follows
  a_irq_follow: assert property (
    |(next_int_status & int_enable) |=> o_irq) // [R11]
    else $error("interrupt low while enabled status bit set");

  // main scenarios
  c_link_change: cover property (link_evt[0] ##1 o_link_raw[0] ##[1:20] !o_link_raw[0]);
  c_masked_irq: cover property (link_mevt[1] ##[1:4] o_irq);
  c_test_set: cover property (o_test_en && wr_cmd_raw[0] ##1 o_cmd_raw[0]);
  c_set_vs_clear: cover property (i_cmd_done[1] && wr_cmd_raw[1] && !o_test_en);

endmodule

// ### tb_mes_event_status.sv
// self-checking bench for the event status block
`include "mes_regs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end

module tb_mes_event_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 0;
  logic i_resetn = 0;
  logic i_psel = 0;
  logic i_penable = 0;
  logic i_pwrite = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, o_link_state, rd, rv;
  logic o_pready, o_pslverr, o_test_en, o_irq, err;
  mes_pkg::mes_status_rd_t i_status_rd = '0;
  mes_pkg::mes_phy_sel_t [1:0] i_phy_sel = '0;
  logic [1:0] i_cmd_done = 2'h0;
  logic [1:0] o_link_raw, o_link_masked, o_cmd_raw;
  logic [1:0] e_raw = 2'h0, e_msk = 2'h0, e_cmd = 2'h0;
  logic [31:0] st = 32'h0;
  logic [31:0] seed = 32'h0000_CDE4;
  int failures = 0;
  int samples_checked = 0;

  // 40 MHz core clock
  always #12.5 i_core_clk = ~i_core_clk;

  mes_event_status #(.NCH(2)) mes_event_status_inst (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_status_rd(i_status_rd), .i_phy_sel(i_phy_sel),
    .i_cmd_done(i_cmd_done), .o_link_raw(o_link_raw), .o_link_masked(o_link_masked),
    .o_cmd_raw(o_cmd_raw), .o_test_en(o_test_en), .o_link_state(o_link_state),
    .o_irq(o_irq));

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // channels that see a link change for this status read
  function automatic logic [1:0] chg(input logic [4:0] a, input logic l);
    chg[0] = (l !== st[a]) && (a === i_phy_sel[0].addr);
    chg[1] = (l !== st[a]) && (a === i_phy_sel[1].addr);
  endfunction

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1 && ++n < 50);
    if (n >= 50) failures++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask

  // status read and command pulses for one cycle, then port checks
  task automatic ev(input logic [4:0] a, input logic l, input logic [1:0] c);
    @(posedge i_core_clk);
    i_status_rd <= '{1'b1, a, l};
    i_cmd_done <= c;
    e_raw |= chg(a, l);
    e_msk |= chg(a, l) & {i_phy_sel[1].link_int_enable, i_phy_sel[0].link_int_enable};
    e_cmd |= c;
    st[a] = l;
    @(posedge i_core_clk);
    i_status_rd <= '0;
    i_cmd_done <= 2'h0;
    #1;
    `CHK("link_raw", e_raw, o_link_raw)
    `CHK("link_masked", e_msk, o_link_masked)
    `CHK("cmd_raw", e_cmd, o_cmd_raw)
    `CHK("link_state", st, o_link_state)
  endtask

  task automatic fin_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    i_phy_sel[0] <= '{5'h03, 1'b1};
    i_phy_sel[1] <= '{5'h0A, 1'b0};
    // every register clear after reset, unmapped address refused
    for (int k = 0; k < 8; k++)
      rdchk(8'(k * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("pslverr", 1'b1, err)
    `CHK("pready", 1'b1, o_pready)
    fin_test("reset");
    // watched, unwatched and unchanged status reads
    ev(5'h03, 1'b1, 2'h0);
    ev(5'h0A, 1'b1, 2'h0);
    ev(5'h0A, 1'b1, 2'h0);
    ev(5'h05, 1'b1, 2'h3);
    wr(`MES_OFF_LINK_RAW, 32'hFFFF_FFFC);
    rdchk(`MES_OFF_LINK_RAW, 32'h3);
    wr(`MES_OFF_LINK_RAW, 32'h1);
    rdchk(`MES_OFF_LINK_RAW, 32'h2);
    wr(`MES_OFF_LINK_MASKED, 32'h1);
    rdchk(`MES_OFF_LINK_MASKED, 32'h0);
    wr(`MES_OFF_CMD_RAW, 32'h2);
    rdchk(`MES_OFF_CMD_RAW, 32'h1);
    fin_test("events");
    // test mode lets written ones set bits
    wr(`MES_OFF_CONTROL, 32'h0002_0000);
    rdchk(`MES_OFF_CONTROL, 32'h0002_0000);
    `CHK("test_en", 1'b1, o_test_en)
    for (int k = 0; k < 3; k++)
    begin
      wr(8'(k * 4), 32'hFFFF_FFFF);
      rdchk(8'(k * 4), 32'h3);
    end
    wr(`MES_OFF_CONTROL, 32'h0);
    wr(`MES_OFF_LINK_RAW, 32'h1);
    wr(`MES_OFF_LINK_RAW, 32'h1);
    rdchk(`MES_OFF_LINK_RAW, 32'h2);
    e_raw = 2'h2;
    e_msk = 2'h3;
    e_cmd = 2'h3;
    fin_test("test_mode");
    // interrupt raised, masked and cleared
    wr(`MES_OFF_INT_CLEAR, 32'h3F);
    wr(`MES_OFF_INT_ENABLE, 32'h01);
    ev(5'h0A, 1'b0, 2'h1);
    @(posedge i_core_clk);
    #1;
    `CHK("irq", 1'b0, o_irq)
    rdchk(`MES_OFF_INT_STATUS, 32'h12);
    ev(5'h03, 1'b0, 2'h0);
    @(posedge i_core_clk);
    #1;
    `CHK("irq", 1'b1, o_irq)
    wr(`MES_OFF_INT_CLEAR, 32'h1);
    @(posedge i_core_clk);
    #1;
    `CHK("irq", 1'b0, o_irq)
    fin_test("interrupt");
    // hardware event beats a clear in the same cycle
    fork
      wr(`MES_OFF_CMD_RAW, 32'h3);
      begin
        repeat (2) @(posedge i_core_clk);
        i_cmd_done <= 2'h1;
        @(posedge i_core_clk);
        i_cmd_done <= 2'h0;
      end
    join
    e_cmd = 2'h1;
    rdchk(`MES_OFF_CMD_RAW, 32'h1);
    fin_test("collision");
    // random status reads, enables and clears
    for (int k = 0; k < 60; k++)
    begin
      rv = rnd();
      i_phy_sel[0].link_int_enable <= rv[12];
      ev(rv[2] ? rv[8:4] : (rv[3] ? 5'h0A : 5'h03), rv[9], rv[11:10]);
      wr(`MES_OFF_LINK_RAW, {30'h0, rv[14:13]});
      e_raw &= ~rv[14:13];
      rdchk(`MES_OFF_LINK_RAW, {30'h0, e_raw});
    end
    fin_test("random");
    tally_and_finish();
  end
endmodule
